// ==== rtl/saod_dma.sv ====
// Function
// R1 - Software loads both bases and size, a multiple of 64 bytes, first.
// R2 - Writing one to transmit enable starts sending the first buffer.
// R3 - First buffer drained: drop active, take timestamp, set its flag, go on.
// R4 - First drained flag with its enable raises the interrupt.
// R5 - Acknowledge write clears the drained flag and withdraws its interrupt.
// R6 - Second buffer drains likewise, then the first again, alternating forever.
// R7 - Both drained before acknowledge: set underrun, switch anyway with stale data.
// R8 - Internal buffer empty when a word is needed sets bandwidth error.
// R9 - One interrupt line for any enabled flag among the four.
// R10 - All four flags stay set until their acknowledge bit is written.
// R11 - An acknowledged flag drops in the cycle after the write.
// R12 - The interrupt input should be level sensitive at the controller.
// R13 - A 32-bit counter on the clock runs from the common reset.
// R14 - Timestamp register holds the count when the last buffer bit leaves.
// R15 - Read-only active bit is high for first buffer, low for second.
// R16 - Acknowledge bits read zero, zero writes ignored, bandwidth ack clears error.
// R17 - Clearing transmit enable stops only after the current word is finished.
// R18 - Fetch each buffer sequentially base to base plus size, staying ahead.
module saod_dma #(
	parameter int DEPTH = 4
) (
	input wire logic CLK_I, // System clock, 40 MHz.
	input wire logic RESET_N_I, // Synchronous reset, active low.
	input wire logic [4:0] REG_ADDR_I, // Register byte offset.
	input wire logic REG_WE_I, // Register write strobe.
	input wire logic REG_RE_I, // Register read strobe.
	input wire logic [31:0] REG_WDATA_I, // Register write data.
	output logic [31:0] REG_RDATA_O, // Read data, one cycle after the strobe.
	output logic MEM_REQ_O, // Highway read request.
	output logic [31:0] MEM_ADDR_O, // Highway word address in bytes.
	input wire logic MEM_GNT_I, // Highway accepts the request.
	input wire logic MEM_RVALID_I, // Highway read data valid.
	input wire logic [31:0] MEM_RDATA_I, // Highway read data.
	input wire logic BIT_TICK_I, // One pulse per output bit period.
	output logic SER_DATA_O, // Serial output bit, LSB first.
	output logic IRQ_O // Level interrupt request.
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	saod_pkg::saod_state_t state_reg, state_next;
	logic [31:0] base_reg [2], base_next [2];
	logic [31:0] size_reg, size_next;
	logic [3:0] ien_reg, ien_next;
	logic tx_en_reg, tx_en_next;
	logic [3:0] flags_reg, flags_next;
	logic active_reg, active_next;
	logic [31:0] tcount_reg, tcount_next;
	logic [31:0] tstamp_reg, tstamp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic ser_reg, ser_next;
	logic req_reg, req_next;
	logic wait_reg, wait_next;
	logic fetch_buf_reg, fetch_buf_next;
	logic [31:0] fetch_off_reg, fetch_off_next;
	logic [31:0] addr_reg, addr_next;
	logic pend_last_reg, pend_last_next;
	logic pend_buf_reg, pend_buf_next;
	logic [31:0] fifo_data_reg [DEPTH], fifo_data_next [DEPTH];
	logic [1:0] fifo_tag_reg [DEPTH], fifo_tag_next [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CNT_W-1:0] count_reg, count_next;
	logic [31:0] shift_reg, shift_next;
	logic [4:0] bitcnt_reg, bitcnt_next;
	logic word_valid_reg, word_valid_next;
	logic word_last_reg, word_last_next;
	logic word_buf_reg, word_buf_next;

	logic ctl_wr, tick_last, buf_end, push, pop, start;
	logic [3:0] ack, set;
	logic [31:0] off_step;

	// Decode of strobes and the moment the final bit of a word leaves.
	assign ctl_wr = REG_WE_I && (REG_ADDR_I == saod_pkg::OFF_CONTROL);
	assign ack = ctl_wr ? REG_WDATA_I[saod_pkg::CTL_ACK_LSB +: 4] : 4'h0; // [R16]
	assign tick_last = BIT_TICK_I && word_valid_reg && (bitcnt_reg == saod_pkg::LAST_BIT);
	assign buf_end = tick_last && word_last_reg;
	assign start = ctl_wr && REG_WDATA_I[saod_pkg::CTL_TX_EN] && (state_reg == saod_pkg::SAOD_IDLE);
	assign off_step = fetch_off_reg + saod_pkg::BYTES_PER_WORD;
	assign push = wait_reg && MEM_RVALID_I;
	// A cleared enable lets the word in flight finish but loads no further word.
	assign pop = (count_reg != '0) && (!word_valid_reg || tick_last) && (state_reg == saod_pkg::SAOD_RUN)
		&& tx_en_reg && !start; // [R17]

	// Hardware events; each one wins over an acknowledge in the same cycle.
	always_comb begin
		set = 4'h0;
		set[saod_pkg::FLG_FIRST] = buf_end && !word_buf_reg; // [R3]
		set[saod_pkg::FLG_SECOND] = buf_end && word_buf_reg; // [R6]
		set[saod_pkg::FLG_UDR] = buf_end && (word_buf_reg ? flags_reg[saod_pkg::FLG_FIRST]
			: flags_reg[saod_pkg::FLG_SECOND]); // [R7]
		set[saod_pkg::FLG_BW] = tick_last && tx_en_reg && (count_reg == '0) && !push; // [R8]
	end

	// Next-state logic for registers, fetch engine, internal buffer and serializer.
	always_comb begin
		state_next = state_reg;
		base_next = base_reg;
		size_next = size_reg;
		ien_next = ien_reg;
		tx_en_next = tx_en_reg;
		tcount_next = tcount_reg + 32'h0000_0001; // [R13]
		tstamp_next = tstamp_reg;
		active_next = active_reg;
		req_next = req_reg;
		wait_next = wait_reg;
		fetch_buf_next = fetch_buf_reg;
		fetch_off_next = fetch_off_reg;
		addr_next = addr_reg;
		pend_last_next = pend_last_reg;
		pend_buf_next = pend_buf_reg;
		fifo_data_next = fifo_data_reg;
		fifo_tag_next = fifo_tag_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		shift_next = shift_reg;
		bitcnt_next = bitcnt_reg;
		word_valid_next = word_valid_reg;
		word_last_next = word_last_reg;
		word_buf_next = word_buf_reg;
		ser_next = ser_reg;
		// Sticky flags: set beats clear, a clear lands one cycle after the write.
		flags_next = (flags_reg & ~ack) | set; // [R10] [R11] [R5]
		// Register writes; acknowledge bits are not stored anywhere.
		if (REG_WE_I) begin
			case (REG_ADDR_I)
				saod_pkg::OFF_CONTROL: begin
					ien_next = REG_WDATA_I[saod_pkg::CTL_IEN_LSB +: 4];
					tx_en_next = REG_WDATA_I[saod_pkg::CTL_TX_EN];
				end
				saod_pkg::OFF_FIRST_BASE: base_next[0] = REG_WDATA_I;
				saod_pkg::OFF_SECOND_BASE: base_next[1] = REG_WDATA_I;
				saod_pkg::OFF_SIZE: size_next = REG_WDATA_I;
				default: ;
			endcase
		end
		// Read mux; the control word shows enables only, acks read as zero.
		rdata_next = rdata_reg;
		if (REG_RE_I) begin
			case (REG_ADDR_I)
				saod_pkg::OFF_STATUS: rdata_next = {27'h0, active_reg, flags_reg}; // [R15]
				saod_pkg::OFF_CONTROL: rdata_next = {23'h0, tx_en_reg, ien_reg, 4'h0}; // [R16]
				saod_pkg::OFF_FIRST_BASE: rdata_next = base_reg[0];
				saod_pkg::OFF_SECOND_BASE: rdata_next = base_reg[1];
				saod_pkg::OFF_SIZE: rdata_next = size_reg;
				saod_pkg::OFF_TSTAMP: rdata_next = tstamp_reg;
				default: rdata_next = saod_pkg::RST_WORD;
			endcase
		end
		// Run control: a fresh start rewinds to the first buffer.
		case (state_reg)
			saod_pkg::SAOD_IDLE: begin
				if (start) begin
					state_next = saod_pkg::SAOD_RUN; // [R2]
					fetch_buf_next = 1'b0;
					fetch_off_next = saod_pkg::RST_WORD;
					active_next = 1'b1;
					wr_ptr_next = '0;
					rd_ptr_next = '0;
					count_next = '0;
				end
			end
			saod_pkg::SAOD_RUN: begin
				// Stopping waits for the word in flight to finish its last bit.
				if (!tx_en_reg && (!word_valid_reg || tick_last) && !req_reg && !wait_reg) begin
					state_next = saod_pkg::SAOD_IDLE; // [R17]
				end
			end
			default: state_next = saod_pkg::SAOD_IDLE;
		endcase
		// Fetch one word at a time; only issue when a slot is guaranteed free.
		if (req_reg && MEM_GNT_I) begin
			req_next = 1'b0;
			wait_next = 1'b1;
		end else if (!req_reg && !wait_reg && (state_reg == saod_pkg::SAOD_RUN) && tx_en_reg
			&& (count_reg < CNT_W'(DEPTH))) begin
			req_next = 1'b1; // [R18]
			addr_next = base_reg[fetch_buf_reg] + fetch_off_reg;
			pend_buf_next = fetch_buf_reg;
			pend_last_next = (off_step >= size_reg);
			if (off_step >= size_reg) begin
				fetch_off_next = saod_pkg::RST_WORD;
				fetch_buf_next = !fetch_buf_reg; // [R6]
			end else begin
				fetch_off_next = off_step;
			end
		end
		if (push) begin
			wait_next = 1'b0;
			fifo_data_next[wr_ptr_reg] = MEM_RDATA_I;
			fifo_tag_next[wr_ptr_reg] = {pend_buf_reg, pend_last_reg};
			wr_ptr_next = PTR_W'(wr_ptr_reg + 1'b1);
		end
		// Serializer: shift one bit per tick, reload from the internal buffer.
		if (BIT_TICK_I) begin
			ser_next = word_valid_reg ? shift_reg[0] : 1'b0;
			shift_next = {1'b0, shift_reg[31:1]};
			bitcnt_next = bitcnt_reg + 5'h01;
		end
		if (tick_last) begin
			word_valid_next = 1'b0;
		end
		if (buf_end) begin
			tstamp_next = tcount_reg; // [R14]
			active_next = word_buf_reg; // [R3] [R15]
		end
		if (pop) begin
			shift_next = fifo_data_reg[rd_ptr_reg];
			word_last_next = fifo_tag_reg[rd_ptr_reg][0];
			word_buf_next = fifo_tag_reg[rd_ptr_reg][1];
			word_valid_next = 1'b1;
			bitcnt_next = 5'h00;
			rd_ptr_next = PTR_W'(rd_ptr_reg + 1'b1);
		end
		if (!start) begin
			count_next = CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));
		end
		// One level line for all four enabled flags.
		irq_next = |(flags_next & ien_next); // [R4] [R9]
	end

	// State registers; everything runs every edge.
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			state_reg <= saod_pkg::SAOD_IDLE;
			base_reg <= '{default: saod_pkg::RST_WORD};
			size_reg <= saod_pkg::RST_WORD;
			ien_reg <= saod_pkg::RST_FLAGS;
			tx_en_reg <= 1'b0;
			flags_reg <= saod_pkg::RST_FLAGS;
			active_reg <= saod_pkg::RST_ACTIVE;
			tcount_reg <= saod_pkg::RST_WORD;
			tstamp_reg <= saod_pkg::RST_WORD;
			rdata_reg <= saod_pkg::RST_WORD;
			irq_reg <= 1'b0;
			ser_reg <= 1'b0;
			req_reg <= 1'b0;
			wait_reg <= 1'b0;
			fetch_buf_reg <= 1'b0;
			fetch_off_reg <= saod_pkg::RST_WORD;
			addr_reg <= saod_pkg::RST_WORD;
			pend_last_reg <= 1'b0;
			pend_buf_reg <= 1'b0;
			fifo_data_reg <= '{default: saod_pkg::RST_WORD};
			fifo_tag_reg <= '{default: 2'h0};
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			shift_reg <= saod_pkg::RST_WORD;
			bitcnt_reg <= 5'h00;
			word_valid_reg <= 1'b0;
			word_last_reg <= 1'b0;
			word_buf_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			base_reg <= base_next;
			size_reg <= size_next;
			ien_reg <= ien_next;
			tx_en_reg <= tx_en_next;
			flags_reg <= flags_next;
			active_reg <= active_next;
			tcount_reg <= tcount_next;
			tstamp_reg <= tstamp_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			ser_reg <= ser_next;
			req_reg <= req_next;
			wait_reg <= wait_next;
			fetch_buf_reg <= fetch_buf_next;
			fetch_off_reg <= fetch_off_next;
			addr_reg <= addr_next;
			pend_last_reg <= pend_last_next;
			pend_buf_reg <= pend_buf_next;
			fifo_data_reg <= fifo_data_next;
			fifo_tag_reg <= fifo_tag_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			shift_reg <= shift_next;
			bitcnt_reg <= bitcnt_next;
			word_valid_reg <= word_valid_next;
			word_last_reg <= word_last_next;
			word_buf_reg <= word_buf_next;
		end
	end

	// Outputs straight from flip-flops.
	assign REG_RDATA_O = rdata_reg;
	assign MEM_REQ_O = req_reg;
	assign MEM_ADDR_O = addr_reg;
	assign SER_DATA_O = ser_reg;
	assign IRQ_O = irq_reg;

	// Checks on the flag, timestamp, interrupt, ack read-back and stop behaviour.
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);

	a_first_drain_sets: assert property (buf_end && !word_buf_reg |=> // [R3]
		flags_reg[saod_pkg::FLG_FIRST] && !active_reg) else $error("first drain not flagged");
	a_second_drain_sets: assert property (buf_end && word_buf_reg |=> // [R6]
		flags_reg[saod_pkg::FLG_SECOND] && active_reg) else $error("second drain not flagged");
	a_ack_clears_flag: assert property (ctl_wr && REG_WDATA_I[saod_pkg::FLG_FIRST] && !set[0] // [R11]
		|=> !flags_reg[saod_pkg::FLG_FIRST]) else $error("ack did not clear flag");
	a_flag_stays_set: assert property (flags_reg[saod_pkg::FLG_UDR] && !ack[saod_pkg::FLG_UDR] // [R10]
		|=> flags_reg[saod_pkg::FLG_UDR]) else $error("sticky flag lost");
	a_underrun_both_drained: assert property (buf_end && word_buf_reg // [R7]
		&& flags_reg[saod_pkg::FLG_FIRST] |=> flags_reg[saod_pkg::FLG_UDR])
		else $error("underrun missed");
	a_bw_error_raise: assert property (set[saod_pkg::FLG_BW] |=> flags_reg[saod_pkg::FLG_BW]) // [R8]
		else $error("bandwidth error missed");
	a_irq_level: assert property (IRQ_O == |(flags_reg & ien_reg)) // [R9]
		else $error("interrupt level wrong");
	a_tstamp_capture: assert property (buf_end |=> tstamp_reg == $past(tcount_reg)) // [R14]
		else $error("timestamp not captured");
	a_ack_reads_zero: assert property (REG_RE_I && REG_ADDR_I == saod_pkg::OFF_CONTROL // [R16]
		|=> REG_RDATA_O[3:0] == 4'h0) else $error("ack bits read nonzero");
	a_stop_after_word: assert property (!tx_en_reg && word_valid_reg && !tick_last // [R17]
		|=> state_reg == saod_pkg::SAOD_RUN) else $error("stopped mid word");
	a_counter_steps: assert property (RESET_N_I |=> tcount_reg == $past(tcount_reg) + 32'h0000_0001) // [R13]
		else $error("timestamp counter stalled");

	c_first_drain: cover property (set[saod_pkg::FLG_FIRST]);
	c_second_drain: cover property (set[saod_pkg::FLG_SECOND]);
	c_underrun: cover property (set[saod_pkg::FLG_UDR]);
	c_bw_error: cover property (set[saod_pkg::FLG_BW]);
endmodule : saod_dma

// ==== rtl/saod_pkg.sv ====
package saod_pkg;
	// Register map, byte offsets on the register port.
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_STATUS = 5'h00;
	localparam logic [4:0] OFF_CONTROL = 5'h04;
	localparam logic [4:0] OFF_FIRST_BASE = 5'h08;
	localparam logic [4:0] OFF_SECOND_BASE = 5'h0C;
	localparam logic [4:0] OFF_SIZE = 5'h10;
	localparam logic [4:0] OFF_TSTAMP = 5'h14;

	// Flag positions in the status register; acks and enables use the same order.
	localparam int FLG_FIRST = 0;
	localparam int FLG_SECOND = 1;
	localparam int FLG_BW = 2;
	localparam int FLG_UDR = 3;
	localparam int NUM_FLAGS = 4;
	localparam int STAT_ACTIVE = 4;

	// Control register: acks in [3:0], interrupt enables in [7:4], transmit enable.
	localparam int CTL_ACK_LSB = 0;
	localparam int CTL_IEN_LSB = 4;
	localparam int CTL_TX_EN = 8;

	// Word geometry of the memory stream.
	localparam int WORD_BITS = 32;
	localparam logic [31:0] BYTES_PER_WORD = 32'h0000_0004;
	localparam logic [4:0] LAST_BIT = 5'h1F;

	// Values after reset.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic RST_ACTIVE = 1'b1;

	typedef enum logic {SAOD_IDLE, SAOD_RUN} saod_state_t;
endpackage : saod_pkg

// ==== tb/saod_mem_model.sv ====
// Memory highway stand-in: grants and answers after random delays, one word in flight.
module saod_mem_model (
	input wire logic clk_i, // Clock.
	input wire logic rst_n_i, // Synchronous reset, active low.
	input wire logic req_i, // Read request from the unit.
	input wire logic [31:0] addr_i, // Byte address of the word.
	input wire logic stall_i, // Holds off every grant while high.
	input wire logic [3:0] rnd_i, // Random bits that pace grant and answer.
	input wire logic [31:0] key_i, // Scrambles memory contents.
	output logic gnt_o, // Request accepted.
	output logic rvalid_o, // Read data valid.
	output logic [31:0] rdata_o // Read data.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pend;
	logic [31:0] paddr;
	// A stalled highway is how the bench starves the internal buffer.
	assign gnt_o = req_i && !stall_i && rnd_i[0] && !pend;
	// Outside a valid beat the data bus toggles so that stale data never looks right.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pend <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
		end else if (pend && rnd_i[1]) begin
			pend <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= paddr ^ key_i;
		end else begin
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (gnt_o) begin
				pend <= 1'b1;
				paddr <= addr_i;
			end
		end
	end
endmodule : saod_mem_model

// ==== tb/serial_audio_out_dma_tb.sv ====
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin fails++; \
	$display("BAD %s expected %h seen %h", n, e, g); end end
module serial_audio_out_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, tick = 1'b0, tick_d = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, maddr, mrdata, key = 32'h0, b1, b2, rd_v, ts_exp;
	logic mreq, gnt, rvalid, ser, irq, stall = 1'b0, tick_on = 1'b0, mon_on = 1'b0;
	logic [3:0] rnd = 4'h0;
	int seed = 32'hd26c44eb, fails = 0, checks_done = 0, nbits = 0, nreq = 0;
	int cyc = 0, tick_cyc = 0, tcnt = 0;
	saod_dma #(.DEPTH(4)) i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WE_I(we), .REG_RE_I(re), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
		.MEM_REQ_O(mreq), .MEM_ADDR_O(maddr), .MEM_GNT_I(gnt), .MEM_RVALID_I(rvalid),
		.MEM_RDATA_I(mrdata), .BIT_TICK_I(tick), .SER_DATA_O(ser), .IRQ_O(irq));
	saod_mem_model i_mem (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .addr_i(maddr),
		.stall_i(stall), .rnd_i(rnd), .key_i(key), .gnt_o(gnt), .rvalid_o(rvalid),
		.rdata_o(mrdata));
	// Clock at 40 MHz.
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Buffers alternate every 16 words of a 64-byte size.
	function automatic logic [31:0] exp_addr(input int w);
		exp_addr = (((w / 16) % 2) ? b2 : b1) + 32'(4 * (w % 16));
	endfunction : exp_addr
	function automatic logic exp_bit(input int n);
		logic [31:0] d;
		d = exp_addr(n / 32) ^ key;
		exp_bit = d[n % 32];
	endfunction : exp_bit
	// Bit ticks every fourth cycle, random pacing bits, and a free cycle count from reset.
	always @(posedge clk) begin
		tcnt <= tcnt + 1;
		tick <= tick_on && (tcnt % 4 == 0);
		rnd <= 4'($random(seed));
		if (tick) tick_cyc <= cyc;
		if (rst_n) cyc <= cyc + 1;
	end
	// Watch the wire and the highway addresses against the expected stream.
	always @(posedge clk) begin
		tick_d <= tick;
		if (tick_d && mon_on) begin
			`CHK("serial bit", exp_bit(nbits), ser)
			if (nbits % 512 == 511) ts_exp <= 32'(tick_cyc);
			nbits <= nbits + 1;
		end
		if (mreq && gnt) begin
			`CHK("fetch address", exp_addr(nreq), maddr)
			nreq <= nreq + 1;
		end
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 rd_v = rdata;
	endtask : rd
	task automatic wait_bits(input int n);
		for (int i = 0; i < 20000 && nbits < n; i++) @(posedge clk);
	endtask : wait_bits
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	// A hang is cut off well past the expected run of about 8000 cycles.
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(saod_pkg::OFF_STATUS);
		`CHK("status at reset", 32'h0000_0010, rd_v)
		rd(saod_pkg::OFF_CONTROL);
		`CHK("control at reset", 32'h0000_0000, rd_v)
		rd(5'h18);
		`CHK("unmapped read", 32'h0000_0000, rd_v)
		key = $random(seed);
		b1 = $random(seed) & 32'hFFFF_FFC0;
		b2 = $random(seed) & 32'hFFFF_FFC0;
		// Bases and a 64-byte size go in before transmission is enabled.
		wr(saod_pkg::OFF_FIRST_BASE, b1);
		wr(saod_pkg::OFF_SECOND_BASE, b2);
		wr(saod_pkg::OFF_SIZE, 32'h0000_0040);
		rd(saod_pkg::OFF_SECOND_BASE);
		`CHK("second base", b2, rd_v)
		mon_on = 1'b1;
		wr(saod_pkg::OFF_CONTROL, 32'h0000_01F0);
		// Ticks start late so the first word is already fetched.
		repeat (60) @(posedge clk);
		tick_on <= 1'b1;
		wait_bits(512);
		rd(saod_pkg::OFF_STATUS);
		`CHK("first drained", 32'h0000_0001, rd_v)
		`CHK("irq first", 1'b1, irq)
		rd(saod_pkg::OFF_TSTAMP);
		`CHK("timestamp", ts_exp, rd_v)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_01F0);
		rd(saod_pkg::OFF_STATUS);
		`CHK("zero ack ignored", 32'h0000_0001, rd_v)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_01F1);
		rd(saod_pkg::OFF_STATUS);
		`CHK("first acked", 32'h0000_0000, rd_v)
		`CHK("irq withdrawn", 1'b0, irq)
		wait_bits(1024);
		rd(saod_pkg::OFF_STATUS);
		`CHK("second drained", 32'h0000_0012, rd_v)
		// Second buffer is left unacknowledged so the next switch underruns.
		wait_bits(1536);
		rd(saod_pkg::OFF_STATUS);
		`CHK("underrun", 32'h0000_000B, rd_v)
		// The interrupt is a level; each enable gates its own flag.
		wr(saod_pkg::OFF_CONTROL, 32'h0000_0180);
		repeat (2) @(posedge clk);
		`CHK("irq underrun only", 1'b1, irq)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_0100);
		repeat (2) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_010F);
		rd(saod_pkg::OFF_STATUS);
		`CHK("all acked", 32'h0000_0000, rd_v)
		mon_on = 1'b0;
		stall <= 1'b1;
		repeat (1000) @(posedge clk);
		rd(saod_pkg::OFF_STATUS);
		`CHK("bandwidth error", 32'h0000_0004, rd_v)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_0140);
		repeat (2) @(posedge clk);
		`CHK("irq bandwidth", 1'b1, irq)
		stall <= 1'b0;
		repeat (300) @(posedge clk);
		wr(saod_pkg::OFF_CONTROL, 32'h0000_0104);
		rd(saod_pkg::OFF_STATUS);
		`CHK("bandwidth acked", 32'h0000_0000, rd_v)
		wr(saod_pkg::OFF_CONTROL, 32'h0000_0000);
		repeat (400) @(posedge clk);
		`CHK("stopped fetch", 1'b0, mreq)
		`CHK("stopped wire", 1'b0, ser)
		end_sim();
	end
endmodule : serial_audio_out_dma_tb
